/* lcfm_pkg.sv */
// Constants shared by the LED channel fault monitor
package lcfm_pkg;
   localparam int NCH = 12;
   localparam int CLK_PERIOD_NS = 20;
   localparam int QUAL_TIME_NS = 5000;
   localparam int QUAL_CYCLES = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] QUAL_LIMIT = CNT_W'(QUAL_CYCLES);
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_OE_MASK = 12'h004;
   localparam logic [11:0] ADDR_HS_MASK = 12'h008;
   localparam logic [11:0] ADDR_GS_MASK = 12'h00c;
   localparam logic [11:0] ADDR_OP_MASK = 12'h010;
   localparam logic [11:0] ADDR_STATUS1 = 12'h014;
   localparam logic [11:0] ADDR_CURRENT_REFERENCE_PIN = 12'h018;
   localparam logic [11:0] ADDR_HS_RES = 12'h01c;
   localparam logic [11:0] ADDR_GS_RES = 12'h020;
   localparam logic [11:0] ADDR_OP_RES = 12'h024;
   localparam logic [11:0] ADDR_AJ_RES = 12'h028;
   localparam logic [11:0] ADDR_CMD = 12'h02c;
   // Register indices from decode
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_OE_MASK = 4'h1;
   localparam logic [3:0] IDX_HS_MASK = 4'h2;
   localparam logic [3:0] IDX_GS_MASK = 4'h3;
   localparam logic [3:0] IDX_OP_MASK = 4'h4;
   localparam logic [3:0] IDX_STATUS1 = 4'h5;
   localparam logic [3:0] IDX_CURRENT_REFERENCE_PIN = 4'h6;
   localparam logic [3:0] IDX_HS_RES = 4'h7;
   localparam logic [3:0] IDX_GS_RES = 4'h8;
   localparam logic [3:0] IDX_OP_RES = 4'h9;
   localparam logic [3:0] IDX_AJ_RES = 4'ha;
   localparam logic [3:0] IDX_CMD = 4'hb;
   localparam logic [3:0] IDX_NONE = 4'hf;
   // Control register fields
   localparam int CTRL_HS_GLOBAL = 0;
   localparam int CTRL_GS_GLOBAL = 1;
   localparam int CTRL_OP_GLOBAL = 2;
   localparam int CTRL_AJ_GLOBAL = 3;
   localparam int CTRL_VSEL_LSB = 4;
   localparam int CTRL_W = 6;
   // Status flag group 1 fields
   localparam int ST_OVERTEMP = 0;
   localparam int ST_ANY_SHORT = 1;
   localparam int ST_ANY_OPEN = 2;
   localparam int ST_ANY_ADJ = 3;
   localparam int ST_SUPPLY_LOW = 4;
   localparam int ST_CLOCK_FAULT = 5;
   localparam int ST_RESET_EVENT = 6;
   localparam int ST_W = 7;
   // Command register field
   localparam int CMD_STATUS_RESET = 0;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam logic [NCH-1:0] MASK_RESET = 12'h000;
   localparam logic [NCH-1:0] RES_RESET = 12'h000;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   // Supply threshold select code that leaves detection off
   localparam logic [1:0] VSEL_OFF = 2'h0;
   // Reference resistor diagnosis codes that signal a fault
   localparam logic [1:0] CURRENT_REFERENCE_PIN_BAD_LO = 2'h0;
   localparam logic [1:0] CURRENT_REFERENCE_PIN_BAD_HI = 2'h3;
endpackage

/* lcfm_sync.sv */
// Two flip-flop synchroniser for comparator outputs
module lcfm_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } lcfm_sync_state_t;

   lcfm_sync_state_t r;
   lcfm_sync_state_t next_r;

   always_comb begin
      next_r = r;
      next_r.stage1 = async_in;
      next_r.stage2 = r.stage1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sync_out = r.stage2;
endmodule

/* lcfm_hold_timer.sv */
// Measures how long a level has been stable high or low
module lcfm_hold_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   output logic long_high,
   output logic long_low
);
   typedef struct packed {
      logic prev;
      logic [lcfm_pkg::CNT_W-1:0] cnt;
   } lcfm_timer_state_t;

   lcfm_timer_state_t r;
   lcfm_timer_state_t next_r;

   always_comb begin
      next_r = r;
      next_r.prev = level;
      if (level != r.prev) begin
         next_r.cnt = lcfm_pkg::CNT_ZERO;
      end else if (r.cnt <= lcfm_pkg::QUAL_LIMIT) begin
         next_r.cnt = r.cnt + lcfm_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Stable for more than the qualification time
   assign long_high = r.prev && (r.cnt > lcfm_pkg::QUAL_LIMIT);
   assign long_low = !r.prev && (r.cnt > lcfm_pkg::QUAL_LIMIT);
endmodule

/* lcfm_fault_monitor.sv */
// LED channel fault monitor with APB register access
//
// The APB slave port and the register offsets were decided locally.
module lcfm_fault_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [lcfm_pkg::NCH-1:0] led_lit,
   input wire logic [lcfm_pkg::NCH-1:0] cmp_diff_below_short,
   input wire logic [lcfm_pkg::NCH-1:0] cmp_out_below_open,
   input wire logic [lcfm_pkg::NCH-1:0] cmp_diff_above_short,
   input wire logic cmp_sense_below_supply,
   input wire logic overtemp_warn_in,
   input wire logic clock_fault_in,
   input wire logic [1:0] current_reference_pin_diag_result,
   input wire logic supply_detect_reset,
   output logic fault_out,
   output logic fault_oe
);
   localparam int N = lcfm_pkg::NCH;

   typedef struct packed {
      logic [lcfm_pkg::CTRL_W-1:0] ctrl;
      logic [N-1:0] output_enable_mask;
      logic [N-1:0] high_short_chan_mask;
      logic [N-1:0] ground_short_chan_mask;
      logic [N-1:0] open_chan_mask;
      logic [N-1:0] high_short_result;
      logic [N-1:0] ground_short_result;
      logic [N-1:0] open_result;
      logic [N-1:0] adjacent_result;
      logic overtemp_warn_flag;
      logic any_short_flag;
      logic any_open_flag;
      logic any_adjacent_short_flag;
      logic supply_low_flag;
      logic clock_fault_flag;
      logic reset_event_flag;
      logic [1:0] current_reference_pin;
      logic [31:0] rdata;
      logic slverr;
      logic fault;
   } lcfm_state_t;

   lcfm_state_t r;
   lcfm_state_t next_r;

   // Maps a byte address to a register index
   function automatic logic [3:0] reg_index(input logic [11:0] addr);
      unique case (addr)
         lcfm_pkg::ADDR_CTRL: reg_index = lcfm_pkg::IDX_CTRL;
         lcfm_pkg::ADDR_OE_MASK: reg_index = lcfm_pkg::IDX_OE_MASK;
         lcfm_pkg::ADDR_HS_MASK: reg_index = lcfm_pkg::IDX_HS_MASK;
         lcfm_pkg::ADDR_GS_MASK: reg_index = lcfm_pkg::IDX_GS_MASK;
         lcfm_pkg::ADDR_OP_MASK: reg_index = lcfm_pkg::IDX_OP_MASK;
         lcfm_pkg::ADDR_STATUS1: reg_index = lcfm_pkg::IDX_STATUS1;
         lcfm_pkg::ADDR_CURRENT_REFERENCE_PIN: reg_index = lcfm_pkg::IDX_CURRENT_REFERENCE_PIN;
         lcfm_pkg::ADDR_HS_RES: reg_index = lcfm_pkg::IDX_HS_RES;
         lcfm_pkg::ADDR_GS_RES: reg_index = lcfm_pkg::IDX_GS_RES;
         lcfm_pkg::ADDR_OP_RES: reg_index = lcfm_pkg::IDX_OP_RES;
         lcfm_pkg::ADDR_AJ_RES: reg_index = lcfm_pkg::IDX_AJ_RES;
         lcfm_pkg::ADDR_CMD: reg_index = lcfm_pkg::IDX_CMD;
         default: reg_index = lcfm_pkg::IDX_NONE;
      endcase
   endfunction

   // Reference resistor diagnosis reads as a fault
   function automatic logic current_reference_pin_bad(input logic [1:0] code);
      current_reference_pin_bad = (code == lcfm_pkg::CURRENT_REFERENCE_PIN_BAD_LO) || (code == lcfm_pkg::CURRENT_REFERENCE_PIN_BAD_HI);
   endfunction

   // Synchronised comparator outputs
   logic [N-1:0] s_diff_below_short;
   logic [N-1:0] s_out_below_open;
   logic [N-1:0] s_diff_above_short;
   logic s_sense_low;

   lcfm_sync #(.W(3 * N + 1)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({cmp_diff_below_short, cmp_out_below_open, cmp_diff_above_short, cmp_sense_below_supply}),
      .sync_out({s_diff_below_short, s_out_below_open, s_diff_above_short, s_sense_low})
   );

   // Per channel lit, unlit and neighbour-difference qualification
   logic [N-1:0] lit_long;
   logic [N-1:0] unlit_long;
   logic [N-1:0] nb_diff;
   logic [N-1:0] nb_diff_long;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_chan
         logic left_diff;
         logic right_diff;
         if (g == 0) begin : gen_first
            assign left_diff = 1'b0;
         end else begin : gen_left
            assign left_diff = led_lit[g] ^ led_lit[g-1];
         end
         if (g == N - 1) begin : gen_last
            assign right_diff = 1'b0;
         end else begin : gen_right
            assign right_diff = led_lit[g] ^ led_lit[g+1];
         end
         assign nb_diff[g] = left_diff | right_diff;

         lcfm_hold_timer u_lit (
            .pclk(pclk),
            .presetn(presetn),
            .level(led_lit[g]),
            .long_high(lit_long[g]),
            .long_low(unlit_long[g])
         );

         lcfm_hold_timer u_adj (
            .pclk(pclk),
            .presetn(presetn),
            .level(nb_diff[g]),
            .long_high(nb_diff_long[g]),
            .long_low()
         );
      end
   endgenerate

   // Detection enables per channel
   logic [N-1:0] hs_active;
   logic [N-1:0] gs_active;
   logic [N-1:0] op_active;
   logic [N-1:0] aj_active;
   logic vsel_on;
   logic [3:0] idx;
   logic wr_access;
   logic setup;
   logic clr;
   logic [N-1:0] hs_set;
   logic [N-1:0] gs_set;
   logic [N-1:0] op_set;
   logic [N-1:0] aj_set;
   logic [lcfm_pkg::ST_W-1:0] status1;

   always_comb begin
      hs_active = r.output_enable_mask & r.high_short_chan_mask
         & {N{r.ctrl[lcfm_pkg::CTRL_HS_GLOBAL]}} & lit_long;
      gs_active = r.ground_short_chan_mask & {N{r.ctrl[lcfm_pkg::CTRL_GS_GLOBAL]}} & unlit_long;
      op_active = r.output_enable_mask & r.open_chan_mask
         & {N{r.ctrl[lcfm_pkg::CTRL_OP_GLOBAL]}} & lit_long;
      aj_active = {N{r.ctrl[lcfm_pkg::CTRL_AJ_GLOBAL]}} & nb_diff_long;
      vsel_on = r.ctrl[lcfm_pkg::CTRL_VSEL_LSB +: 2] != lcfm_pkg::VSEL_OFF;
      hs_set = hs_active & s_diff_below_short;
      gs_set = gs_active & s_out_below_open;
      op_set = op_active & s_out_below_open;
      aj_set = aj_active & s_diff_above_short;
   end

   always_comb begin
      idx = reg_index(paddr);
      setup = psel && !penable;
      wr_access = psel && penable && pwrite && (idx != lcfm_pkg::IDX_NONE);
      clr = wr_access && (idx == lcfm_pkg::IDX_CMD) && pwdata[lcfm_pkg::CMD_STATUS_RESET];
      status1 = '0;
      status1[lcfm_pkg::ST_OVERTEMP] = r.overtemp_warn_flag;
      status1[lcfm_pkg::ST_ANY_SHORT] = r.any_short_flag;
      status1[lcfm_pkg::ST_ANY_OPEN] = r.any_open_flag;
      status1[lcfm_pkg::ST_ANY_ADJ] = r.any_adjacent_short_flag;
      status1[lcfm_pkg::ST_SUPPLY_LOW] = r.supply_low_flag;
      status1[lcfm_pkg::ST_CLOCK_FAULT] = r.clock_fault_flag;
      status1[lcfm_pkg::ST_RESET_EVENT] = r.reset_event_flag;
   end

   always_comb begin
      next_r = r;
      next_r.current_reference_pin = current_reference_pin_diag_result;
      // Register writes take effect in the access phase
      if (wr_access) begin
         unique case (idx)
            lcfm_pkg::IDX_CTRL: next_r.ctrl = pwdata[lcfm_pkg::CTRL_W-1:0];
            lcfm_pkg::IDX_OE_MASK: next_r.output_enable_mask = pwdata[N-1:0];
            lcfm_pkg::IDX_HS_MASK: next_r.high_short_chan_mask = pwdata[N-1:0];
            lcfm_pkg::IDX_GS_MASK: next_r.ground_short_chan_mask = pwdata[N-1:0];
            lcfm_pkg::IDX_OP_MASK: next_r.open_chan_mask = pwdata[N-1:0];
            default: begin
            end
         endcase
      end
      // Sticky results: a set in the clearing cycle wins
      next_r.high_short_result = (r.high_short_result & ~{N{clr}}) | hs_set;
      next_r.ground_short_result = (r.ground_short_result & ~{N{clr}}) | gs_set;
      next_r.open_result = (r.open_result & ~{N{clr}}) | op_set;
      next_r.adjacent_result = (r.adjacent_result & ~{N{clr}}) | aj_set;
      next_r.any_short_flag = (r.any_short_flag && !clr) || (|hs_set) || (|gs_set);
      next_r.any_open_flag = (r.any_open_flag && !clr) || (|op_set);
      next_r.any_adjacent_short_flag = (r.any_adjacent_short_flag && !clr) || (|aj_set);
      next_r.supply_low_flag = (r.supply_low_flag && !clr) || (vsel_on && s_sense_low);
      next_r.overtemp_warn_flag = (r.overtemp_warn_flag && !clr) || overtemp_warn_in;
      next_r.clock_fault_flag = (r.clock_fault_flag && !clr) || clock_fault_in;
      next_r.reset_event_flag = (r.reset_event_flag && !clr) || supply_detect_reset;
      // Read data is captured in the setup phase
      if (setup) begin
         next_r.slverr = (idx == lcfm_pkg::IDX_NONE);
         unique case (idx)
            lcfm_pkg::IDX_CTRL: next_r.rdata = 32'(r.ctrl);
            lcfm_pkg::IDX_OE_MASK: next_r.rdata = 32'(r.output_enable_mask);
            lcfm_pkg::IDX_HS_MASK: next_r.rdata = 32'(r.high_short_chan_mask);
            lcfm_pkg::IDX_GS_MASK: next_r.rdata = 32'(r.ground_short_chan_mask);
            lcfm_pkg::IDX_OP_MASK: next_r.rdata = 32'(r.open_chan_mask);
            lcfm_pkg::IDX_STATUS1: next_r.rdata = 32'(status1);
            lcfm_pkg::IDX_CURRENT_REFERENCE_PIN: next_r.rdata = 32'(r.current_reference_pin);
            lcfm_pkg::IDX_HS_RES: next_r.rdata = 32'(r.high_short_result);
            lcfm_pkg::IDX_GS_RES: next_r.rdata = 32'(r.ground_short_result);
            lcfm_pkg::IDX_OP_RES: next_r.rdata = 32'(r.open_result);
            lcfm_pkg::IDX_AJ_RES: next_r.rdata = 32'(r.adjacent_result);
            default: next_r.rdata = lcfm_pkg::DATA_ZERO;
         endcase
      end
      // Fault pin pull-down request
      next_r.fault = next_r.overtemp_warn_flag || next_r.any_short_flag || next_r.any_open_flag
         || next_r.any_adjacent_short_flag || next_r.supply_low_flag || next_r.clock_fault_flag
         || next_r.reset_event_flag || current_reference_pin_bad(current_reference_pin_diag_result);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.ctrl <= lcfm_pkg::CTRL_RESET;
         r.output_enable_mask <= lcfm_pkg::MASK_RESET;
         r.high_short_chan_mask <= lcfm_pkg::MASK_RESET;
         r.ground_short_chan_mask <= lcfm_pkg::MASK_RESET;
         r.open_chan_mask <= lcfm_pkg::MASK_RESET;
         r.high_short_result <= lcfm_pkg::RES_RESET;
         r.ground_short_result <= lcfm_pkg::RES_RESET;
         r.open_result <= lcfm_pkg::RES_RESET;
         r.adjacent_result <= lcfm_pkg::RES_RESET;
         r.reset_event_flag <= 1'b1;
         r.fault <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.rdata;
   assign pready = psel && penable;
   assign pslverr = psel && penable && r.slverr;
   // Open drain: drive low only while a fault is present
   assign fault_out = 1'b0;
   assign fault_oe = r.fault;
endmodule

/* lcfm_front_model.sv */
// Behavioural comparator front end facing the fault monitor
module lcfm_front_model (
   input wire logic [lcfm_pkg::NCH-1:0] led_lit,
   input wire logic [lcfm_pkg::NCH-1:0] hs_flt,
   input wire logic [lcfm_pkg::NCH-1:0] gs_flt,
   input wire logic [lcfm_pkg::NCH-1:0] op_flt,
   input wire logic [lcfm_pkg::NCH-1:0] aj_flt,
   input wire logic sup_low,
   output logic [lcfm_pkg::NCH-1:0] cmp_diff_below_short,
   output logic [lcfm_pkg::NCH-1:0] cmp_out_below_open,
   output logic [lcfm_pkg::NCH-1:0] cmp_diff_above_short,
   output logic cmp_sense_below_supply
);
   timeunit 1ns;
   timeprecision 1ps;
   // Supply short shows a small drop only while the channel sinks current
   assign cmp_diff_below_short = hs_flt & led_lit;
   // Open shows while lit, ground short while unlit
   assign cmp_out_below_open = (op_flt & led_lit) | (gs_flt & ~led_lit);
   assign cmp_diff_above_short = aj_flt;
   assign cmp_sense_below_supply = sup_low;
endmodule

/* lcfm_fault_monitor_asserts.sv */
// Port-level assertions for the LED channel fault monitor
module lcfm_fault_monitor_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic overtemp_warn_in,
   input wire logic [1:0] current_reference_pin_diag_result,
   input wire logic supply_detect_reset,
   input wire logic fault_out,
   input wire logic fault_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic current_reference_pin_ok;
   logic clr;
   assign current_reference_pin_ok = current_reference_pin_diag_result != lcfm_pkg::CURRENT_REFERENCE_PIN_BAD_LO && current_reference_pin_diag_result != lcfm_pkg::CURRENT_REFERENCE_PIN_BAD_HI;
   assign clr = psel && penable && pwrite && paddr == lcfm_pkg::ADDR_CMD && pwdata[0];
   property p_sink;
      fault_out == 1'b0;
   endproperty
   a_sink: assert property (p_sink) else $error("fault data high");
   property p_rst_flag;
      $rose(presetn) |-> fault_oe;
   endproperty
   a_rst_flag: assert property (p_rst_flag) else $error("no fault after reset");
   property p_overtemp;
      overtemp_warn_in |=> fault_oe;
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemp not signalled");
   property p_rst_event;
      supply_detect_reset |=> fault_oe;
   endproperty
   a_rst_event: assert property (p_rst_event) else $error("reset event not signalled");
   property p_current_reference_pin;
      !current_reference_pin_ok |-> ##[1:2] fault_oe;
   endproperty
   a_current_reference_pin: assert property (p_current_reference_pin) else $error("current_reference_pin fault not signalled");
   property p_sticky;
      fault_oe && !clr && current_reference_pin_ok && $past(current_reference_pin_ok) && $past(current_reference_pin_ok, 2) |=> fault_oe;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault dropped without clear");
   property p_ready;
      pready == (psel && penable);
   endproperty
   a_ready: assert property (p_ready) else $error("ready timing wrong");
   property p_err;
      pslverr |-> pready && prdata == lcfm_pkg::DATA_ZERO;
   endproperty
   a_err: assert property (p_err) else $error("error without zero data");
endmodule

/* tb.sv */
// Self-checking bench for the LED channel fault monitor
bind lcfm_fault_monitor lcfm_fault_monitor_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .overtemp_warn_in(overtemp_warn_in),
   .current_reference_pin_diag_result(current_reference_pin_diag_result), .supply_detect_reset(supply_detect_reset), .fault_out(fault_out),
   .fault_oe(fault_oe)
);
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] ST = lcfm_pkg::ADDR_STATUS1;
   localparam logic [11:0] CT = lcfm_pkg::ADDR_CTRL;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_out, fault_oe, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [lcfm_pkg::NCH-1:0] led_lit, hs_flt, gs_flt, op_flt, aj_flt, c_bs, c_bo, c_as;
   logic c_sup, sup_low, ot_in, cf_in, sdr_in;
   logic [1:0] current_reference_pin;
   int mismatches;
   int check_count;
   lcfm_fault_monitor u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_lit(led_lit),
      .cmp_diff_below_short(c_bs), .cmp_out_below_open(c_bo), .cmp_diff_above_short(c_as),
      .cmp_sense_below_supply(c_sup), .overtemp_warn_in(ot_in), .clock_fault_in(cf_in),
      .current_reference_pin_diag_result(current_reference_pin), .supply_detect_reset(sdr_in), .fault_out(fault_out), .fault_oe(fault_oe)
   );
   lcfm_front_model u_front (
      .led_lit(led_lit), .hs_flt(hs_flt), .gs_flt(gs_flt), .op_flt(op_flt), .aj_flt(aj_flt),
      .sup_low(sup_low), .cmp_diff_below_short(c_bs), .cmp_out_below_open(c_bo),
      .cmp_diff_above_short(c_as), .cmp_sense_below_supply(c_sup)
   );
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [11:0] d);
      apb(1'b1, a, {20'h0_0000, d});
   endtask
   task automatic rchk(input logic [11:0] a, input logic [11:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, {20'h0_0000, e});
   endtask
   task automatic clr();
      wr(lcfm_pkg::ADDR_CMD, 12'h001);
      idle(3);
   endtask
   task automatic t_reset();
      chk(32'(fault_oe), 32'h0000_0001);
      rchk(ST, 12'h040);
      rchk(lcfm_pkg::ADDR_HS_RES, 12'h000);
      clr();
      chk(32'(fault_oe), 32'h0000_0000);
      apb(1'b0, 12'h030, 32'h0000_0000);
      chk({err, rd[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_current_reference_pin();
      for (int c = 0; c < 4; c++) begin
         current_reference_pin <= 2'(c);
         idle(4);
         chk(32'(fault_oe), 32'(c == 0 || c == 3));
         rchk(lcfm_pkg::ADDR_CURRENT_REFERENCE_PIN, 12'(c));
      end
      current_reference_pin <= 2'h1;
      idle(4);
   endtask
   task automatic t_flags();
      for (int i = 0; i < 3; i++) begin
         {sdr_in, cf_in, ot_in} <= 3'(1 << i);
         idle(1);
         {sdr_in, cf_in, ot_in} <= 3'h0;
         idle(3);
         chk(32'(fault_oe), 32'h0000_0001);
         rchk(ST, (i == 0) ? 12'h001 : (i == 1) ? 12'h020 : 12'h040);
         clr();
         chk(32'(fault_oe), 32'h0000_0000);
      end
   endtask
   task automatic t_hs();
      wr(CT, 12'h00f);
      wr(lcfm_pkg::ADDR_OE_MASK, 12'h001);
      wr(lcfm_pkg::ADDR_HS_MASK, 12'h003);
      led_lit <= 12'hfff;
      hs_flt <= 12'h003;
      idle(200);
      rchk(lcfm_pkg::ADDR_HS_RES, 12'h000);
      idle(100);
      rchk(lcfm_pkg::ADDR_HS_RES, 12'h001);
      rchk(ST, 12'h002);
      hs_flt <= 12'h000;
      idle(5);
      rchk(lcfm_pkg::ADDR_HS_RES, 12'h001);
      clr();
      rchk(lcfm_pkg::ADDR_HS_RES, 12'h000);
   endtask
   task automatic t_gs();
      wr(lcfm_pkg::ADDR_OE_MASK, 12'h000);
      wr(lcfm_pkg::ADDR_GS_MASK, 12'h004);
      led_lit <= 12'h000;
      gs_flt <= 12'h00c;
      idle(300);
      rchk(lcfm_pkg::ADDR_GS_RES, 12'h004);
      rchk(ST, 12'h002);
      gs_flt <= 12'h000;
      clr();
   endtask
   task automatic t_open();
      wr(CT, 12'h00b);
      wr(lcfm_pkg::ADDR_OE_MASK, 12'hfff);
      wr(lcfm_pkg::ADDR_OP_MASK, 12'h010);
      led_lit <= 12'hfff;
      op_flt <= 12'h030;
      idle(300);
      rchk(lcfm_pkg::ADDR_OP_RES, 12'h000);
      wr(CT, 12'h00f);
      idle(5);
      rchk(lcfm_pkg::ADDR_OP_RES, 12'h010);
      rchk(ST, 12'h004);
      op_flt <= 12'h000;
      clr();
   endtask
   task automatic t_adj();
      wr(CT, 12'h008);
      led_lit <= 12'h555;
      aj_flt <= 12'h001;
      idle(300);
      rchk(lcfm_pkg::ADDR_AJ_RES, 12'h001);
      rchk(ST, 12'h008);
      wr(CT, 12'h000);
      clr();
      rchk(lcfm_pkg::ADDR_AJ_RES, 12'h000);
      aj_flt <= 12'h000;
   endtask
   task automatic t_sup();
      sup_low <= 1'b1;
      idle(5);
      rchk(ST, 12'h000);
      for (int v = 1; v < 4; v++) begin
         wr(CT, 12'(v << 4));
         idle(5);
         rchk(ST, 12'h010);
         wr(CT, 12'h000);
         clr();
      end
      sup_low <= 1'b0;
   endtask
   task automatic end_sim();
      $display("mismatches=%0d check_count=%0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      idle(6000);
      mismatches++;
      end_sim();
   end
   initial begin
      {presetn, psel, penable, pwrite, ot_in, cf_in, sdr_in, sup_low} = 8'h00;
      {led_lit, hs_flt, gs_flt, op_flt, aj_flt} = 60'h000_0000_0000_0000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      current_reference_pin = 2'h1;
      mismatches = 0;
      check_count = 0;
      idle(16);
      presetn <= 1'b1;
      idle(2);
      t_reset();
      t_current_reference_pin();
      t_flags();
      t_hs();
      t_gs();
      t_open();
      t_adj();
      t_sup();
      end_sim();
   end
endmodule
